// ### hdl/smbibs_pkg.sv
package smbibs_pkg;

  // ****************************************
  // Sizes and reset values
  // ****************************************
  localparam int        SMBIBS_REG_NUM      = 9;
  localparam int        SMBIBS_IDX_W        = 4;
  localparam logic [3:0] SMBIBS_COUNT_IDX   = 4'h7;
  localparam logic [7:0] SMBIBS_COUNT_RST   = 8'h08;
  localparam logic [7:0] SMBIBS_COUNT_MASK  = 8'h1F;
  localparam logic [7:0] SMBIBS_CTRL0_RST   = 8'h18;
  localparam logic [7:0] SMBIBS_CTRL1_RST   = 8'hF7;
  localparam logic [7:0] SMBIBS_CTRL2_RST   = 8'hBD;
  localparam logic [7:0] SMBIBS_CTRL0_WMASK = 8'h18;
  localparam logic [7:0] SMBIBS_CTRL1_WMASK = 8'hF7;
  localparam logic [7:0] SMBIBS_CTRL2_WMASK = 8'hBD;
  // Arbitrary identity values, not tied to any real part
  localparam logic [7:0] SMBIBS_ID_BYTE5    = 8'h11;
  localparam logic [7:0] SMBIBS_ID_BYTE6    = 8'h5A;
  // Input clock watchdog: mclk cycles without an input clock edge
  localparam int        SMBIBS_CLK_TMO_NS   = 1000;
  localparam int        SMBIBS_MCLK_NS      = 50;
  localparam logic [7:0] SMBIBS_CLK_TMO_CYC =
    8'((SMBIBS_CLK_TMO_NS + SMBIBS_MCLK_NS - 1) / SMBIBS_MCLK_NS);

  typedef enum logic [3:0] {
    SMBIBS_IDLE  = 4'h0,
    SMBIBS_ADDR  = 4'h1,
    SMBIBS_AACK  = 4'h3,
    SMBIBS_WBYTE = 4'h2,
    SMBIBS_WACK  = 4'h6,
    SMBIBS_RBYTE = 4'h7,
    SMBIBS_RACK  = 4'h5,
    SMBIBS_WAITP = 4'h4
  } smbibs_state_type;

  // Pins after the synchronisers
  typedef struct packed {
    logic scl;
    logic sda;
  } smbibs_bus_type;

endpackage : smbibs_pkg

// ### hdl/smbibs_sync.sv
`timescale 1ns/1ps
module smbibs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  // Two stages; first stage read only by the second
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      meta_ff  <= '1;
      sync_out <= '1;
    end
    else
    begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule : smbibs_sync

// ### hdl/smbibs_slave.sv
`timescale 1ns/1ps
module smbibs_slave (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [3:0] addr_sel,
  input  wire logic       inclk_div,
  input  wire logic [7:0] status0_in,
  input  wire logic [7:0] status3_in,
  output logic [7:0]      ctrl0_out,
  output logic [7:0]      ctrl1_out,
  output logic [7:0]      ctrl2_out,
  output logic            port_active
);
  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    smbibs_pkg::smbibs_state_type st;
    smbibs_pkg::smbibs_bus_type   bus_d;
    logic [7:0]                   shreg;
    logic [2:0]                   bitcnt;
    logic [1:0]                   phase;
    logic                         rd;
    logic [3:0]                   idx;
    logic [7:0]                   left;
    logic                         sda_oe;
    logic [7:0]                   ctrl0;
    logic [7:0]                   ctrl1;
    logic [7:0]                   ctrl2;
    logic [7:0]                   count;
    logic [6:0]                   own_addr;
    logic                         clk_d;
    logic [7:0]                   tmo;
    logic                         active;
    logic [1:0]                   warm;
  } smbibs_state_s_type;

  smbibs_state_s_type     st_ff;
  smbibs_state_s_type     nxt_st;
  smbibs_pkg::smbibs_bus_type bus_s;
  logic [6:0]             pins_s;

  smbibs_sync #(.WIDTH(7)) u_sync (
    .mclk     (mclk),
    .reset    (reset),
    .async_in ({scl_in, sda_in, inclk_div, addr_sel}),
    .sync_out (pins_s)
  );
  assign bus_s = {pins_s[6], pins_s[5]};
  // ****************************************
  // Helpers
  // ****************************************
  // Two bits per tri-level pin, first pin in the upper pair: 00 low, 01 mid, 11 high
  function automatic logic [6:0] addr_decode(input logic [3:0] sel);
    logic [7:0] a;
    unique case (sel)
      4'h0: a = 8'hD8;
      4'h1: a = 8'hDA;
      4'h3: a = 8'hDE;
      4'h4: a = 8'hC2;
      4'h5: a = 8'hC4;
      4'h7: a = 8'hC6;
      4'hC: a = 8'hCA;
      4'hD: a = 8'hCC;
      4'hF: a = 8'hCE;
      default: a = 8'hD8;
    endcase
    return a[7:1];
  endfunction : addr_decode

  function automatic logic [7:0] reg_read(input smbibs_state_s_type s,
                                          input logic [7:0] st0,
                                          input logic [7:0] st3,
                                          input logic [3:0] i);
    logic [7:0] v;
    unique case (i)
      4'h0: v = (st0 & ~smbibs_pkg::SMBIBS_CTRL0_WMASK) | s.ctrl0;
      4'h1: v = s.ctrl1;
      4'h2: v = s.ctrl2;
      4'h3: v = st3;
      4'h5: v = smbibs_pkg::SMBIBS_ID_BYTE5;
      4'h6: v = smbibs_pkg::SMBIBS_ID_BYTE6;
      4'h7: v = s.count;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : reg_read

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [7:0] byte_c;
    logic [7:0] rdat;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_c  = 1'b0;
    stop_c   = 1'b0;
    byte_c   = 8'h00;
    rdat     = reg_read(st_ff, status0_in, status3_in, st_ff.idx);
    nxt_st   = st_ff;
    nxt_st.bus_d = bus_s;
    nxt_st.clk_d = pins_s[4];
    nxt_st.own_addr = addr_decode(pins_s[3:0]);
    // Input clock watchdog; sync reset level settling is no clock edge
    nxt_st.warm = st_ff.warm + 2'(st_ff.warm != 2'h3);
    if (pins_s[4] != st_ff.clk_d && st_ff.warm == 2'h3)
    begin
      nxt_st.tmo    = smbibs_pkg::SMBIBS_CLK_TMO_CYC;
      nxt_st.active = 1'b1;
    end
    else if (st_ff.tmo != 8'h00)
      nxt_st.tmo = st_ff.tmo - 8'h01;
    else
      nxt_st.active = 1'b0;
    scl_rise = bus_s.scl & ~st_ff.bus_d.scl;
    scl_fall = ~bus_s.scl & st_ff.bus_d.scl;
    start_c  = st_ff.bus_d.scl & bus_s.scl & st_ff.bus_d.sda & ~bus_s.sda;
    stop_c   = st_ff.bus_d.scl & bus_s.scl & ~st_ff.bus_d.sda & bus_s.sda;
    byte_c   = {st_ff.shreg[6:0], bus_s.sda};
    if (!nxt_st.active)
    begin
      nxt_st.st     = smbibs_pkg::SMBIBS_IDLE;
      nxt_st.sda_oe = 1'b0;
    end
    else if (stop_c)
    begin
      nxt_st.st     = smbibs_pkg::SMBIBS_IDLE;
      nxt_st.sda_oe = 1'b0;
    end
    else if (start_c)
    begin
      nxt_st.st     = smbibs_pkg::SMBIBS_ADDR;
      nxt_st.bitcnt = 3'd0;
      nxt_st.sda_oe = 1'b0;
    end
    else
    begin
      unique case (st_ff.st)
        smbibs_pkg::SMBIBS_IDLE, smbibs_pkg::SMBIBS_WAITP: ;
        smbibs_pkg::SMBIBS_ADDR, smbibs_pkg::SMBIBS_WBYTE:
        begin
          if (scl_rise)
          begin
            nxt_st.shreg  = byte_c;
            nxt_st.bitcnt = st_ff.bitcnt + 3'd1;
            if (st_ff.bitcnt == 3'd7)
            begin
              if (st_ff.st == smbibs_pkg::SMBIBS_ADDR)
              begin
                if (byte_c[7:1] == st_ff.own_addr)
                begin
                  nxt_st.st = smbibs_pkg::SMBIBS_AACK;
                  nxt_st.rd = byte_c[0];
                  nxt_st.phase = 2'd0;
                end
                else
                  nxt_st.st = smbibs_pkg::SMBIBS_WAITP;
              end
              else
              begin
                nxt_st.st = smbibs_pkg::SMBIBS_WACK;
                unique case (st_ff.phase)
                  2'd0: nxt_st.idx = byte_c[3:0];
                  2'd1: nxt_st.left = byte_c;
                  default:
                  begin
                    if (st_ff.left != 8'h00)
                    begin
                      nxt_st.left = st_ff.left - 8'h01;
                      nxt_st.idx  = st_ff.idx + 4'h1;
                      // Non-writable bits and indices stay untouched
                      unique case (st_ff.idx)
                        4'h0: nxt_st.ctrl0 = byte_c & smbibs_pkg::SMBIBS_CTRL0_WMASK;
                        4'h1: nxt_st.ctrl1 = byte_c & smbibs_pkg::SMBIBS_CTRL1_WMASK;
                        4'h2: nxt_st.ctrl2 = byte_c & smbibs_pkg::SMBIBS_CTRL2_WMASK;
                        4'h7: nxt_st.count = byte_c & smbibs_pkg::SMBIBS_COUNT_MASK;
                        default: ;
                      endcase
                    end
                  end
                endcase
                if (st_ff.phase != 2'd2)
                  nxt_st.phase = st_ff.phase + 2'd1;
              end
            end
          end
        end
        smbibs_pkg::SMBIBS_AACK, smbibs_pkg::SMBIBS_WACK:
        begin
          // Drive ack low during the ninth clock
          if (scl_fall && !st_ff.sda_oe)
            nxt_st.sda_oe = 1'b1;
          else if (scl_fall && st_ff.sda_oe)
          begin
            nxt_st.sda_oe = 1'b0;
            nxt_st.bitcnt = 3'd0;
            if (st_ff.st == smbibs_pkg::SMBIBS_AACK && st_ff.rd)
            begin
              nxt_st.st     = smbibs_pkg::SMBIBS_RBYTE;
              nxt_st.shreg  = st_ff.count;
              nxt_st.idx    = 4'h0;
              nxt_st.left   = st_ff.count + 8'h01;
              nxt_st.sda_oe = ~st_ff.count[7];
            end
            else
              nxt_st.st = smbibs_pkg::SMBIBS_WBYTE;
          end
        end
        smbibs_pkg::SMBIBS_RBYTE:
        begin
          if (scl_fall)
          begin
            nxt_st.bitcnt = st_ff.bitcnt + 3'd1;
            if (st_ff.bitcnt == 3'd7)
            begin
              nxt_st.st     = smbibs_pkg::SMBIBS_RACK;
              nxt_st.sda_oe = 1'b0;
            end
            else
            begin
              nxt_st.shreg  = {st_ff.shreg[6:0], 1'b0};
              nxt_st.sda_oe = ~st_ff.shreg[6];
            end
          end
        end
        smbibs_pkg::SMBIBS_RACK:
        begin
          if (scl_rise)
          begin
            if (bus_s.sda || st_ff.left == 8'h00)
              nxt_st.st = smbibs_pkg::SMBIBS_WAITP;
            else
              nxt_st.st = smbibs_pkg::SMBIBS_RACK;
            nxt_st.bitcnt = bus_s.sda ? 3'd1 : 3'd0;
          end
          else if (scl_fall && st_ff.bitcnt == 3'd0)
          begin
            nxt_st.st     = smbibs_pkg::SMBIBS_RBYTE;
            nxt_st.shreg  = rdat;
            nxt_st.sda_oe = ~rdat[7];
            nxt_st.idx    = st_ff.idx + 4'h1;
            nxt_st.left   = st_ff.left - 8'h01;
          end
        end
        default: nxt_st.st = smbibs_pkg::SMBIBS_IDLE;
      endcase
    end
  end
  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st_ff        <= '0;
      st_ff.bus_d  <= '1;
      st_ff.ctrl0  <= smbibs_pkg::SMBIBS_CTRL0_RST;
      st_ff.ctrl1  <= smbibs_pkg::SMBIBS_CTRL1_RST;
      st_ff.ctrl2  <= smbibs_pkg::SMBIBS_CTRL2_RST;
      st_ff.count  <= smbibs_pkg::SMBIBS_COUNT_RST;
      st_ff.own_addr <= 7'h6C;
    end
    else
      st_ff <= nxt_st;
  end
  assign sda_out     = 1'b0;
  assign sda_oe      = st_ff.sda_oe;
  assign ctrl0_out   = st_ff.ctrl0;
  assign ctrl1_out   = st_ff.ctrl1;
  assign ctrl2_out   = st_ff.ctrl2;
  assign port_active = st_ff.active;
endmodule : smbibs_slave

// ### dv/smbibs_monitor.sv
`timescale 1ns/1ps
module smbibs_monitor (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       inclk_div,
  input wire logic [7:0] ctrl1_out,
  input wire logic       port_active
);
  logic [7:0] gap_ff;
  logic [7:0] nxt_gap;
  logic       clk_q_ff;

  // ****************************************
  // Input clock gap, counted on the raw pin
  // ****************************************
  always_comb nxt_gap = (inclk_div != clk_q_ff) ? 8'h00 : gap_ff + 8'(gap_ff != 8'hFF);

  always_ff @(posedge mclk)
  begin
    clk_q_ff <= inclk_div;
    gap_ff   <= reset ? 8'hFF : nxt_gap;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  // ****************************************
  // Properties
  // ****************************************
  reset_quiet_a: assert property ($fell(reset) |-> !sda_oe && !port_active)
    else $error("port live after reset");
  clk_needed_a: assert property (sda_oe |-> port_active)
    else $error("drives data without input clock");
  // Sync delay plus watchdog, so some slack
  clk_watch_a: assert property (port_active |-> gap_ff <= smbibs_pkg::SMBIBS_CLK_TMO_CYC + 8'h08)
    else $error("port stays active on a stopped clock");
  idle_frozen_a: assert property (!port_active |=> $stable(ctrl1_out))
    else $error("control changed while inactive");
  ack_scl_low_a: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data pulled while clock high");
  oe_hold_a: assert property ($rose(sda_oe) |=> sda_oe [*8])
    else $error("pulled bit too short");
  free_scl_low_a: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("data freed while clock high");
  pull_low_a: assert property (sda_oe |-> !sda_out)
    else $error("open drain drives high");
  fixed_bit_a: assert property (ctrl1_out[3] == smbibs_pkg::SMBIBS_CTRL1_RST[3])
    else $error("reserved control bit changed");
  stop_free_a: assert property (scl_in && $rose(sda_in) |-> ##4 !sda_oe)
    else $error("data held after stop");
endmodule : smbibs_monitor

bind smbibs_slave smbibs_monitor smbibs_monitor_inst (.mclk(mclk), .reset(reset),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .inclk_div(inclk_div), .ctrl1_out(ctrl1_out), .port_active(port_active));

// ### dv/smbibs_host_model.sv
`timescale 1ns/1ps
module smbibs_host_model #(
  parameter int QTR = 50
) (
  input  wire logic mclk,
  input  wire logic sda_line,
  output logic      scl_out,
  output logic      sda_pull
);
  initial
  begin
    scl_out  = 1'b1;
    sda_pull = 1'b0;
  end

  // ****************************************
  // Bus phases, quarter bit each, SCL 100 kHz
  // ****************************************
  task automatic q(input logic scl, input logic pull);
    scl_out  <= scl;
    sda_pull <= pull;
    repeat (QTR) @(posedge mclk);
  endtask : q

  task automatic start();
    q(scl_out, 1'b0);
    q(1'b1, 1'b0);
    q(1'b1, 1'b1);
    q(1'b0, 1'b1);
  endtask : start

  task automatic stop();
    q(1'b0, 1'b1);
    q(1'b1, 1'b1);
    q(1'b1, 1'b0);
  endtask : stop

  task automatic bit_io(input logic b, output logic r);
    q(1'b0, !b);
    q(1'b1, !b);
    r = sda_line;
    q(1'b1, !b);
    q(1'b0, !b);
  endtask : bit_io

  // Ack bit is ours when reading: 0 goes on, 1 ends
  task automatic byte_io(input logic [7:0] tx, input logic ackb, output logic [7:0] rx,
                         output logic ak);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ackb, ak);
  endtask : byte_io
endmodule : smbibs_host_model

// ### dv/smbus_indexed_block_slave_tb.sv
`timescale 1ns/1ps
module smbus_indexed_block_slave_tb;
  logic       mclk      = 1'b0;
  logic       reset     = 1'b1;
  logic       clk_run   = 1'b0;
  logic       inclk_div = 1'b0;
  logic [3:0] addr_sel  = 4'h0;
  logic [7:0] st0       = 8'h00;
  logic [7:0] st3       = 8'h00;
  logic       scl, pull, sda_oe, sda_out, port_active;
  logic [7:0] ctrl0, ctrl1, ctrl2;
  logic [7:0] w [9];
  int         num_errors      = 0;
  int         samples_checked = 0;
  // Pull-up: released line reads high
  wire        sda = !(pull || (sda_oe && !sda_out));

  initial forever #25 mclk = !mclk;
  always @(posedge mclk) if (clk_run) inclk_div <= !inclk_div;

  smbibs_slave smbibs_slave_inst (.mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel), .inclk_div(inclk_div),
    .status0_in(st0), .status3_in(st3), .ctrl0_out(ctrl0), .ctrl1_out(ctrl1),
    .ctrl2_out(ctrl2), .port_active(port_active));
  smbibs_host_model smbibs_host_model_inst (.mclk(mclk), .sda_line(sda), .scl_out(scl),
    .sda_pull(pull));

  // ****************************************
  // Reference model and checks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [7:0] wmask(input int i);
    case (i)
      0: return smbibs_pkg::SMBIBS_CTRL0_WMASK;
      1: return smbibs_pkg::SMBIBS_CTRL1_WMASK;
      2: return smbibs_pkg::SMBIBS_CTRL2_WMASK;
      7: return smbibs_pkg::SMBIBS_COUNT_MASK;
      default: return 8'h00;
    endcase
  endfunction : wmask

  function automatic logic [7:0] exp_byte(input int i);
    case (i)
      0: return w[0] | st0;
      3: return st3;
      5: return smbibs_pkg::SMBIBS_ID_BYTE5;
      6: return smbibs_pkg::SMBIBS_ID_BYTE6;
      default: return w[i];
    endcase
  endfunction : exp_byte

  task automatic put(input logic [7:0] b, input logic nak);
    logic [7:0] rx;
    logic       ak;
    smbibs_host_model_inst.byte_io(b, 1'b1, rx, ak);
    check({7'h00, ak}, {7'h00, nak});
  endtask : put

  task automatic wr_block(input logic [7:0] adr, input int idx, input int n);
    logic [7:0] d;
    smbibs_host_model_inst.start();
    put(adr, 1'b0);
    put(8'(idx), 1'b0);
    put(8'(n), 1'b0);
    for (int i = idx; i < idx + n; i++)
    begin
      // Short counts keep the read-back brief; high bits test the mask
      d = (i == 7) ? 8'($urandom_range(6, 2)) | 8'hE0 : 8'($urandom);
      put(d, 1'b0);
      w[i] = (d & wmask(i)) | (w[i] & ~wmask(i));
    end
    smbibs_host_model_inst.stop();
  endtask : wr_block

  task automatic rd_block(input logic [7:0] adr);
    logic [7:0] rx;
    logic       ak;
    int         n;
    n = int'(w[7]);
    smbibs_host_model_inst.start();
    put(adr, 1'b0);
    put(8'($urandom_range(8, 0)), 1'b0);
    smbibs_host_model_inst.start();
    put(adr | 8'h01, 1'b0);
    smbibs_host_model_inst.byte_io(8'hFF, 1'b0, rx, ak);
    check(rx, w[7]);
    for (int i = 0; i <= n; i++)
    begin
      smbibs_host_model_inst.byte_io(8'hFF, i == n, rx, ak);
      check(rx, exp_byte(i));
    end
    smbibs_host_model_inst.stop();
    check({7'h00, sda_oe}, 8'h00);
  endtask : rd_block

  task automatic tally_and_finish();
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    void'($urandom(85744));
    foreach (w[i]) w[i] = 8'h00;
    w[0] = smbibs_pkg::SMBIBS_CTRL0_RST;
    w[1] = smbibs_pkg::SMBIBS_CTRL1_RST;
    w[2] = smbibs_pkg::SMBIBS_CTRL2_RST;
    w[7] = smbibs_pkg::SMBIBS_COUNT_RST;
    @(posedge mclk);
    st0 <= 8'($urandom) & 8'hE7;
    st3 <= 8'($urandom) & 8'hEF;
    repeat (11) @(posedge mclk);
    reset <= 1'b0;
    smbibs_host_model_inst.start();
    put(8'hD8, 1'b1);
    smbibs_host_model_inst.stop();
    clk_run <= 1'b1;
    repeat (10) @(posedge mclk);
    rd_block(8'hD8);
    wr_block(8'hD8, 0, 4);
    check(ctrl0, w[0]);
    check(ctrl1, w[1]);
    check(ctrl2, w[2]);
    wr_block(8'hD8, 6, 2);
    rd_block(8'hD8);
    addr_sel <= 4'h7;
    smbibs_host_model_inst.start();
    put(8'hD8, 1'b1);
    smbibs_host_model_inst.stop();
    wr_block(8'hC6, 1, 2);
    check(ctrl1, w[1]);
    check(ctrl2, w[2]);
    clk_run <= 1'b0;
    repeat (40) @(posedge mclk);
    check({7'h00, port_active}, 8'h00);
    tally_and_finish();
  end

  initial
  begin
    repeat (100000) @(posedge mclk);
    num_errors++;
    tally_and_finish();
  end
endmodule : smbus_indexed_block_slave_tb
